// ### hdl/bat_pkg.sv
// package: constants and types for the block address translation unit
package bat_pkg;
  localparam logic [31:0] OFS_CONFIG = 32'h0000_0000;
  localparam logic [31:0] OFS_MODE = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
  localparam logic [31:0] OFS_MASK = 32'h0000_000C;
  localparam logic [31:0] OFS_LAST_PA = 32'h0000_0010;
  localparam logic [31:0] OFS_LAST_ERR_VA = 32'h0000_0014;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0002;
  localparam logic [31:0] CONFIG_WMASK = 32'h7E00_0007;
  localparam int UPPER_ATTR_LSB = 28;
  localparam int USER_ATTR_LSB = 25;
  localparam int KERN_ATTR_LSB = 0;
  localparam int ATTR_W = 3;
  localparam int ERR_LEVEL_BIT = 2;
  localparam logic [2:0] ATTR_UNCACHED_A = 3'h2;
  localparam logic [2:0] ATTR_UNCACHED_B = 3'h7;
  localparam logic [2:0] SEG_CACHED_KERN = 3'h4;
  localparam logic [2:0] SEG_UNCACHED_KERN = 3'h5;
  localparam logic [2:0] SEG_LOW_MASKED = 3'h0;
  localparam logic [31:0] DBG_WIN_LO = 32'hFF20_0000;
  localparam logic [31:0] DBG_WIN_HI = 32'hFF3F_FFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int EV_FETCH = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_STORE = 2;
  localparam int EV_BITS = 3;
  typedef enum logic [1:0] {BAT_USER = 2'h0, BAT_KERNEL = 2'h1, BAT_DEBUG = 2'h3} bat_mode_type;
  typedef enum logic [1:0] {BAT_FETCH = 2'h0, BAT_LOAD = 2'h1, BAT_STORE = 2'h2} bat_kind_type;
endpackage

// ### hdl/bat_xlate_if.sv
// interface: one translation port between top and the lookup slice
`timescale 1ns/100ps
`default_nettype none
interface bat_xlate_if;
  import bat_pkg::*;
  logic [31:0] vaddr;
  logic [1:0] size;
  bat_kind_type kind;
  logic [31:0] paddr;
  logic uncached;
  logic addr_err;
  logic to_probe;
  modport req (output vaddr, output size, output kind, input paddr, input uncached,
    input addr_err, input to_probe);
  modport xl (input vaddr, input size, input kind, output paddr, output uncached,
    output addr_err, output to_probe);
endinterface
`default_nettype wire

// ### hdl/bat_slice.sv
// module: combinational translation of one access
`timescale 1ns/100ps
`default_nettype none
module bat_slice
(
  bat_xlate_if.xl x,
  input wire logic [31:0] config_word,
  input wire bat_pkg::bat_mode_type mode,
  input wire logic error_level_flag
);
  import bat_pkg::*;
  wire [2:0] seg = x.vaddr[31:29];
  wire in_user_seg = ~x.vaddr[31];
  wire in_unc_kern = seg == SEG_UNCACHED_KERN;
  wire in_cached_kern = seg == SEG_CACHED_KERN;
  wire in_upper = seg[2] & seg[1];
  wire [2:0] user_attr = config_word[USER_ATTR_LSB +: ATTR_W];
  wire [2:0] kern_attr = config_word[KERN_ATTR_LSB +: ATTR_W];
  wire [2:0] upper_attr = config_word[UPPER_ATTR_LSB +: ATTR_W];
  function automatic logic attr_unc(input logic [2:0] a);
    attr_unc = (a == ATTR_UNCACHED_A) || (a == ATTR_UNCACHED_B);
  endfunction
  wire misalign = (x.size == 2'h1) ? x.vaddr[0] :
    (x.size == 2'h2) ? (x.vaddr[1:0] != 2'h0) : 1'b0;
  wire fetch_mis = (x.kind == BAT_FETCH) && (x.vaddr[1:0] != 2'h0);
  wire protect = (mode == BAT_USER) && x.vaddr[31];
  assign x.addr_err = misalign | fetch_mis | protect;
  assign x.uncached = in_user_seg ? (error_level_flag | attr_unc(user_attr)) :
    in_cached_kern ? attr_unc(kern_attr) :
    in_unc_kern ? 1'b1 :
    attr_unc(upper_attr);
  assign x.paddr = (in_cached_kern | in_unc_kern) ? {SEG_LOW_MASKED, x.vaddr[28:0]} : x.vaddr;
  assign x.to_probe = (mode == BAT_DEBUG) && in_upper &&
    (x.vaddr >= DBG_WIN_LO) && (x.vaddr <= DBG_WIN_HI);
endmodule
`default_nettype wire

// ### hdl/bat_top.sv
// module: block address translation with AHB-Lite register access
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module bat_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic i_valid,
  input wire logic [31:0] i_vaddr,
  output logic [31:0] i_paddr,
  output logic i_uncached,
  output logic i_probe,
  output logic i_fetch_err,
  input wire logic d_valid,
  input wire logic d_write,
  input wire logic [1:0] d_size,
  input wire logic [31:0] d_vaddr,
  output logic [31:0] d_paddr,
  output logic d_uncached,
  output logic d_probe,
  output logic d_load_err,
  output logic d_store_err,
  output logic irq
);
  import bat_pkg::*;
  logic [31:0] config_ff;
  logic [31:0] nxt_config;
  bat_mode_type mode_ff;
  logic [31:0] status_reg_ff;
  logic [EV_BITS-1:0] ev_ff;
  logic [EV_BITS-1:0] mask_ff;
  logic [31:0] last_pa_ff;
  logic [31:0] last_err_va_ff;
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] i_paddr_ff;
  logic i_unc_ff;
  logic i_probe_ff;
  logic i_err_ff;
  logic [31:0] d_paddr_ff;
  logic d_unc_ff;
  logic d_probe_ff;
  logic d_lerr_ff;
  logic d_serr_ff;
  logic irq_ff;
  logic [31:0] hrdata_ff;
  bat_xlate_if ix();
  bat_xlate_if dx();
  wire error_level_flag = status_reg_ff[ERR_LEVEL_BIT];
  // two slices so fetch and data translate in the same cycle
  assign ix.vaddr = i_vaddr;
  assign ix.size = 2'h2;
  assign ix.kind = BAT_FETCH;
  assign dx.vaddr = d_vaddr;
  assign dx.size = d_size;
  assign dx.kind = d_write ? BAT_STORE : BAT_LOAD;
  bat_slice u_islice
  (
    .x(ix),
    .config_word(config_ff),
    .mode(mode_ff),
    .error_level_flag(error_level_flag)
  );
  bat_slice u_dslice
  (
    .x(dx),
    .config_word(config_ff),
    .mode(mode_ff),
    .error_level_flag(error_level_flag)
  );
  wire ahb_take = hsel & hready & htrans[1];
  wire ahb_rd = ahb_take & ~hwrite;
  wire ahb_wr = ahb_take & hwrite;
  wire hit_config = wr_addr_ff[7:0] == OFS_CONFIG[7:0];
  wire hit_mode = wr_addr_ff[7:0] == OFS_MODE[7:0];
  wire hit_status = wr_addr_ff[7:0] == OFS_STATUS[7:0];
  wire hit_mask = wr_addr_ff[7:0] == OFS_MASK[7:0];
  wire wr_config = wr_pend_ff & hit_config;
  wire wr_mode = wr_pend_ff & hit_mode;
  wire wr_status = wr_pend_ff & hit_status;
  wire wr_mask = wr_pend_ff & hit_mask;
  wire [31:0] stat_word = {status_reg_ff[31:EV_BITS+8], ev_ff, status_reg_ff[7:0]};
  wire [EV_BITS-1:0] ev_now = {d_valid & dx.addr_err & d_write,
    d_valid & dx.addr_err & ~d_write, i_valid & ix.addr_err};
  wire [EV_BITS-1:0] ev_clr = wr_status ? hwdata[8 +: EV_BITS] : '0;
  // set beats clear when both land together
  wire [EV_BITS-1:0] nxt_ev = (ev_ff & ~ev_clr) | ev_now;
  wire [31:0] mode_word = {30'h0000_0000, mode_ff};
  wire [31:0] mask_word = {{(32-EV_BITS){1'b0}}, mask_ff};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux = (ra == OFS_CONFIG[7:0]) ? config_ff :
    (ra == OFS_MODE[7:0]) ? mode_word :
    (ra == OFS_STATUS[7:0]) ? stat_word :
    (ra == OFS_MASK[7:0]) ? mask_word :
    (ra == OFS_LAST_PA[7:0]) ? last_pa_ff :
    (ra == OFS_LAST_ERR_VA[7:0]) ? last_err_va_ff : 32'h0000_0000;
  wire [31:0] status_nxt_lo = wr_status ? hwdata : status_reg_ff;
  wire bad_mode = hwdata[1:0] == 2'h2;
  always_comb
  begin
    nxt_config = config_ff;
    if (wr_config)
    begin
      nxt_config = (config_ff & ~CONFIG_WMASK) | (hwdata & CONFIG_WMASK);
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= ahb_wr;
      if (ahb_take)
      begin
        wr_addr_ff <= haddr;
      end
      if (ahb_rd)
      begin
        hrdata_ff <= rd_mux;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_ff <= CONFIG_RESET;
      mode_ff <= BAT_KERNEL;
      status_reg_ff <= 32'h0000_0000;
      ev_ff <= '0;
      mask_ff <= '0;
    end
    else
    begin
      config_ff <= nxt_config;
      if (wr_mode && !bad_mode)
      begin
        mode_ff <= bat_mode_type'(hwdata[1:0]);
      end
      status_reg_ff <= {status_nxt_lo[31:EV_BITS+8], {EV_BITS{1'b0}}, status_nxt_lo[7:0]};
      ev_ff <= nxt_ev;
      if (wr_mask)
      begin
        mask_ff <= hwdata[EV_BITS-1:0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_pa_ff <= 32'h0000_0000;
      last_err_va_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (d_valid)
      begin
        last_pa_ff <= dx.paddr;
      end
      if (d_valid && dx.addr_err)
      begin
        last_err_va_ff <= d_vaddr;
      end
      else if (i_valid && ix.addr_err)
      begin
        last_err_va_ff <= i_vaddr;
      end
      irq_ff <= |(nxt_ev & mask_ff);
    end
  end
  // registered results; caches see them one cycle after the request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      i_paddr_ff <= 32'h0000_0000;
      i_unc_ff <= 1'b0;
      i_probe_ff <= 1'b0;
      i_err_ff <= 1'b0;
      d_paddr_ff <= 32'h0000_0000;
      d_unc_ff <= 1'b0;
      d_probe_ff <= 1'b0;
      d_lerr_ff <= 1'b0;
      d_serr_ff <= 1'b0;
    end
    else
    begin
      i_paddr_ff <= ix.paddr;
      i_unc_ff <= ix.uncached;
      i_probe_ff <= i_valid & ix.to_probe;
      i_err_ff <= i_valid & ix.addr_err;
      d_paddr_ff <= dx.paddr;
      d_unc_ff <= dx.uncached;
      d_probe_ff <= d_valid & dx.to_probe;
      d_lerr_ff <= d_valid & ~d_write & dx.addr_err;
      d_serr_ff <= d_valid & d_write & dx.addr_err;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign i_paddr = i_paddr_ff;
  assign i_uncached = i_unc_ff;
  assign i_probe = i_probe_ff;
  assign i_fetch_err = i_err_ff;
  assign d_paddr = d_paddr_ff;
  assign d_uncached = d_unc_ff;
  assign d_probe = d_probe_ff;
  assign d_load_err = d_lerr_ff;
  assign d_store_err = d_serr_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ### tb/bat_chk.sv
// checker: translation port assertions
`timescale 1ns/100ps
`default_nettype none
module bat_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic i_valid,
  input wire logic [31:0] i_vaddr,
  input wire logic [31:0] i_paddr,
  input wire logic i_uncached,
  input wire logic i_fetch_err,
  input wire logic d_valid,
  input wire logic d_write,
  input wire logic [1:0] d_size,
  input wire logic [31:0] d_vaddr,
  input wire logic [31:0] d_paddr,
  input wire logic d_uncached,
  input wire logic d_probe,
  input wire logic d_load_err,
  input wire logic d_store_err
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_unc_segment: assert property (d_vaddr[31:29] == 3'h5 |=> d_uncached)
    else $error("uncached kernel segment marked cacheable");
  a_low_alias: assert property (d_vaddr[31:30] == 2'h2 |=>
    d_paddr == {3'h0, $past(d_vaddr[28:0])}) else $error("kernel alias wrong");
  a_fetch_alias: assert property (i_vaddr[31:29] == 3'h5 |=> i_uncached &&
    i_paddr == {3'h0, $past(i_vaddr[28:0])}) else $error("fetch path translation wrong");
  a_user_ident: assert property (!d_vaddr[31] |=> d_paddr == $past(d_vaddr))
    else $error("user segment not passed through");
  a_fetch_align: assert property (i_valid && i_vaddr[1:0] != 2'h0 |=> i_fetch_err)
    else $error("misaligned fetch not flagged");
  a_load_align: assert property (d_valid && !d_write && d_size == 2'h1 && d_vaddr[0]
    |=> d_load_err && !d_store_err) else $error("misaligned load not flagged");
  a_store_align: assert property (d_valid && d_write && d_size == 2'h2 &&
    d_vaddr[1:0] != 2'h0 |=> d_store_err && !d_load_err) else $error("store error missing");
  a_no_probe_low: assert property (!d_vaddr[31] |=> !d_probe)
    else $error("probe routed outside window");
  a_byte_no_err: assert property (d_valid && d_size == 2'h0 && !d_vaddr[31] |=>
    !d_load_err && !d_store_err) else $error("spurious address error");
endmodule
bind bat_top bat_chk bat_chk_inst (.hclk, .hresetn, .i_valid, .i_vaddr, .i_paddr,
  .i_uncached, .i_fetch_err, .d_valid, .d_write, .d_size, .d_vaddr, .d_paddr, .d_uncached,
  .d_probe, .d_load_err, .d_store_err);
`default_nettype wire

// ### tb/bat_cpu_model.sv
// partner model: execution unit issuing fetch and data accesses
`timescale 1ns/100ps
`default_nettype none
module bat_cpu_model
(
  input wire logic hclk,
  output logic i_valid,
  output logic [31:0] i_vaddr,
  output logic d_valid,
  output logic d_write,
  output logic [1:0] d_size,
  output logic [31:0] d_vaddr
);
  initial {i_valid, i_vaddr, d_valid, d_write, d_size, d_vaddr} = '0;
  // both paths go out in one cycle; returns once the registered answer is settled
  task automatic issue(input logic iv, input logic [31:0] ia, input logic dv,
    input logic dw, input logic [1:0] ds, input logic [31:0] da);
    @(posedge hclk);
    i_valid <= iv;
    i_vaddr <= ia;
    d_valid <= dv;
    d_write <= dw;
    d_size <= ds;
    d_vaddr <= da;
    @(posedge hclk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### tb/bat_top_tb_top.sv
// testbench: register, translation, error and interrupt scenarios
`timescale 1ns/100ps
`default_nettype none
module bat_top_tb_top;
  import bat_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, i_vaddr, d_vaddr, i_paddr, d_paddr, rd, flags;
  logic [1:0] htrans, d_size;
  logic [2:0] hsize;
  logic i_valid, d_valid, d_write, i_uncached, i_probe, i_fetch_err;
  logic d_uncached, d_probe, d_load_err, d_store_err, irq;
  int n_mismatch, total_checks, cyc;
  assign flags = {24'h0, i_uncached, d_uncached, i_fetch_err, d_load_err, d_store_err,
    i_probe, d_probe, irq};
  bat_top bat_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .i_valid, .i_vaddr, .i_paddr,
    .i_uncached, .i_probe, .i_fetch_err, .d_valid, .d_write, .d_size, .d_vaddr, .d_paddr,
    .d_uncached, .d_probe, .d_load_err, .d_store_err, .irq);
  bat_cpu_model bat_cpu_model_inst (.hclk, .i_valid, .i_vaddr, .d_valid, .d_write,
    .d_size, .d_vaddr);
  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_regs();
    ahb(1'b0, OFS_CONFIG, 32'h0);
    chk("config reset", CONFIG_RESET, rd);
    ahb(1'b0, OFS_MODE, 32'h0);
    chk("mode reset", 32'h0000_0001, rd);
    chk("bus okay", 32'h0, {31'h0, hresp});
    ahb(1'b1, OFS_CONFIG, 32'hFFFF_FFFF);
    ahb(1'b0, OFS_CONFIG, 32'h0);
    chk("config writable", CONFIG_WMASK, rd);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask
  task automatic t_attr();
    logic u;
    for (int a = 0; a < 8; a++)
    begin
      u = (a == 2) || (a == 7);
      ahb(1'b1, OFS_CONFIG, {1'b0, a[2:0], a[2:0], 22'h0, a[2:0]});
      bat_cpu_model_inst.issue(1'b1, 32'hA000_0010, 1'b1, 1'b0, 2'h2, 32'h8000_0020);
      chk("kernel attr", {24'h0, 1'b1, u, 6'h0}, flags);
      chk("kernel paddr", 32'h0000_0020, d_paddr);
      chk("fetch paddr", 32'h0000_0010, i_paddr);
      bat_cpu_model_inst.issue(1'b1, 32'h0000_0100, 1'b1, 1'b1, 2'h2, 32'hC000_0040);
      chk("user upper attr", {24'h0, u, u, 6'h0}, flags);
    end
  endtask
  task automatic t_err_level();
    ahb(1'b1, OFS_CONFIG, 32'h3600_0003);
    ahb(1'b1, OFS_STATUS, 32'h0000_0004);
    bat_cpu_model_inst.issue(1'b1, 32'h0000_0200, 1'b1, 1'b0, 2'h2, 32'h1234_5678);
    chk("err level attr", 32'h0000_00C0, flags);
    chk("err level paddr", 32'h1234_5678, d_paddr);
    ahb(1'b1, OFS_STATUS, 32'h0);
    bat_cpu_model_inst.issue(1'b1, 32'h0000_0200, 1'b1, 1'b0, 2'h2, 32'h1234_5678);
    chk("no err level attr", 32'h0, flags);
  endtask
  task automatic t_errs();
    ahb(1'b1, OFS_MODE, 32'h0);
    bat_cpu_model_inst.issue(1'b1, 32'h8000_0000, 1'b1, 1'b1, 2'h2, 32'h0000_0006);
    chk("user errors", 32'h0000_0028, flags);
    bat_cpu_model_inst.issue(1'b1, 32'h0000_0002, 1'b1, 1'b0, 2'h1, 32'h0000_0003);
    chk("half load error", 32'h0000_0030, flags);
    bat_cpu_model_inst.issue(1'b0, 32'h0, 1'b1, 1'b1, 2'h0, 32'h0000_0005);
    chk("byte store ok", 32'h0, flags);
    ahb(1'b1, OFS_MASK, 32'h0000_0007);
    bat_cpu_model_inst.issue(1'b0, 32'h0, 1'b0, 1'b0, 2'h2, 32'h0);
    chk("irq raised", 32'h0000_0001, flags);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("sticky events", 32'h0000_0700, rd);
    ahb(1'b1, OFS_STATUS, 32'h0000_0700);
    bat_cpu_model_inst.issue(1'b0, 32'h0, 1'b0, 1'b0, 2'h2, 32'h0);
    chk("irq cleared", 32'h0, flags);
    ahb(1'b0, OFS_LAST_PA, 32'h0);
    chk("last data paddr", 32'h0000_0005, rd);
    ahb(1'b0, OFS_LAST_ERR_VA, 32'h0);
    chk("last error vaddr", 32'h0000_0003, rd);
  endtask
  task automatic t_probe();
    ahb(1'b1, OFS_MODE, 32'h0000_0003);
    bat_cpu_model_inst.issue(1'b1, 32'hFF3F_FFFC, 1'b1, 1'b0, 2'h2, DBG_WIN_LO);
    chk("probe in window", 32'h0000_0006, flags);
    bat_cpu_model_inst.issue(1'b1, 32'hFF40_0000, 1'b1, 1'b0, 2'h2, 32'hFF1F_FFFC);
    chk("probe outside", 32'h0, flags);
    ahb(1'b1, OFS_MODE, 32'h0000_0002);
    ahb(1'b0, OFS_MODE, 32'h0);
    chk("mode code refused", 32'h0000_0003, rd);
    ahb(1'b1, OFS_MODE, 32'h0000_0001);
    bat_cpu_model_inst.issue(1'b1, DBG_WIN_LO, 1'b1, 1'b0, 2'h2, 32'hFF3F_FFFC);
    chk("probe kernel", 32'h0, flags);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ceiling well above the roughly 140 cycles the scenarios need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_attr();
    t_err_level();
    t_errs();
    t_probe();
    end_of_test();
  end
endmodule
`default_nettype wire
